//--- common/bdma_defs.svh
/*
 Constants of the banked data memory addressing block: instruction-cycle
 phases, address map figures, decode field positions and reset values.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef BDMA_DEFS_SVH
`define BDMA_DEFS_SVH

`define BDMA_ADDR_W        12
`define BDMA_DATA_W        8
`define BDMA_WORD_W        16
`define BDMA_BANK_W        4
`define BDMA_OFFS_W        8
`define BDMA_BANK_COUNT    16
`define BDMA_BANKS_IMPL    5'h10
`define BDMA_Q1            2'h0
`define BDMA_Q2            2'h1
`define BDMA_Q3            2'h2
`define BDMA_Q4            2'h3
`define BDMA_SECOND_NIBBLE 4'hF
`define BDMA_NIBBLE_HI     15
`define BDMA_NIBBLE_LO     12
`define BDMA_ACCESS_BIT    8
`define BDMA_ACCESS_SPLIT  8'h80
`define BDMA_ACCESS_LOW    12'h000
`define BDMA_ACCESS_HIGH   12'hF00
`define BDMA_SFR_BASE      12'hF80
`define BDMA_RAM_BASE      12'h000
`define BDMA_RAM_DEPTH     3968
`define BDMA_BANK_PTR_ADDR 12'hFE0
`define BDMA_PCL_ADDR      12'hFF9
`define BDMA_BANK_RESET    4'h0

`endif

//--- common/bdma_pkg.sv
/*
 Types of the banked data memory addressing block.
 Assumes the constants header sits on the include path.
*/
`include "bdma_defs.svh"

package bdma_pkg;

   typedef enum logic [2:0] {
      BDMA_OP_NONE,
      BDMA_OP_READ,
      BDMA_OP_WRITE,
      BDMA_OP_LOAD_BANK,
      BDMA_OP_MOVE_FIRST,
      BDMA_OP_SECOND
   } bdma_op_t;

   typedef logic [`BDMA_ADDR_W-1:0] bdma_addr_t;
   typedef logic [`BDMA_DATA_W-1:0] bdma_data_t;

endpackage

//--- common/bdma_ram_if.sv
/*
 Carrier between the addressing logic and the general RAM array.
 Assumes one clock domain; write strobe and address are steady for a clock.
*/
`include "bdma_defs.svh"

interface bdma_ram_if;
   logic [`BDMA_ADDR_W-1:0] addr;
   logic                    we;
   logic [`BDMA_DATA_W-1:0] wdata;
   logic [`BDMA_DATA_W-1:0] rdata;

   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface

//--- logic/bdma_ram.sv
/*
 General RAM array from address 000h up to the special register area.
 Assumes the controller only addresses it below the special register base.
*/
`include "bdma_defs.svh"

module bdma_ram (
   input wire logic clock,
   bdma_ram_if.mem  port_m
);
   import bdma_pkg::*;

   // No reset: contents survive every reset and start unknown
   logic [`BDMA_DATA_W-1:0] mem [0:`BDMA_RAM_DEPTH-1];

   always_ff @(posedge clock) begin
      if (port_m.we) begin
         mem[port_m.addr] <= port_m.wdata; // RULE16
      end
   end

   assign port_m.rdata = mem[port_m.addr];
endmodule

//--- logic/bdma_top.sv
/*
 Data address generation and banking of an 8-bit core: phase divider,
 bank pointer, access window, full-address move and second-word handling.
 Assumes the core presents each instruction word steadily across its cycle
 and supplies the write result before the Q4 clock edge.
*/
`include "bdma_defs.svh"

// Operation
// RULE1 - Second word: top nibble ones, 12-bit literal
// RULE2 - Lone second word executes as no-op
// RULE3 - Every data location has 12-bit address
// RULE4 - Sixteen banks of 256 bytes, all present
// RULE5 - Unimplemented locations read as zero
// RULE6 - Bank pointer high nibble, instruction low byte
// RULE7 - Pointer upper nibble reads zero, ignores writes
// RULE8 - Load-bank-literal writes the bank pointer
// RULE9 - Unimplemented banks drop writes, flags still update
// RULE10 - Full move uses two 12-bit addresses
// RULE11 - Window: bank 0 low, bank 15 high
// RULE12 - Access bit one uses bank pointer
// RULE13 - Access bit zero uses the window
// RULE14 - Window access completes in one cycle
// RULE15 - Extended set changes window, handled elsewhere
// RULE16 - General RAM at 000h, never initialised
// RULE17 - Bank 15 offset F9h writes pc low
// RULE18 - Special registers span F80h to FFFh
// RULE19 - Operand read Q2, destination write Q4
// RULE20 - Window address 000h or F00h plus offset
module bdma_top (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire bdma_pkg::bdma_op_t        cmd_op,
   input  wire logic [`BDMA_WORD_W-1:0]   cmd_word,
   input  wire logic [`BDMA_DATA_W-1:0]   cmd_wdata,
   input  wire logic                      extended_set_enable,
   input  wire logic [`BDMA_DATA_W-1:0]   sfr_rdata,
   output logic [1:0]                     q_phase_r,
   output logic [`BDMA_BANK_W-1:0]        bank_pointer_r,
   output logic [`BDMA_ADDR_W-1:0]        data_addr_r,
   output logic [`BDMA_DATA_W-1:0]        rd_data_r,
   output logic                           rd_valid_r,
   output logic                           flags_update_r,
   output logic                           nop_exec_r,
   output logic                           alt_map_req_r,
   output logic                           move_pending_r,
   output logic                           pc_low_byte_we_r,
   output logic [`BDMA_DATA_W-1:0]        pc_low_byte_data_r,
   output logic                           sfr_we_r,
   output logic                           sfr_re_r,
   output logic [`BDMA_ADDR_W-1:0]        sfr_addr_r,
   output logic [`BDMA_DATA_W-1:0]        sfr_wdata_r
);
   import bdma_pkg::*;

   bdma_ram_if ram_bus ();

   bdma_op_t                 ir_op_r;
   logic [`BDMA_WORD_W-1:0]  ir_word_r;
   logic [`BDMA_DATA_W-1:0]  move_data_r;
   logic [`BDMA_ADDR_W-1:0]  eff_addr;
   logic                     eff_alt;
   logic                     is_second;
   logic                     q1_tick;
   logic                     q2_tick;
   logic                     q4_tick;
   logic                     wr_en;
   logic [`BDMA_DATA_W-1:0]  wr_data;
   logic [`BDMA_DATA_W-1:0]  rd_mux;
   logic                     rd_take;
   logic [`BDMA_ADDR_W-1:0]  next_addr;
   logic                     sfr_rd_req;
   logic                     sfr_wr_req;
   logic                     pc_hit;

   // Window map: low half to bank 0, high half to bank 15
   function automatic bdma_addr_t window_addr(input logic [`BDMA_OFFS_W-1:0] offs);
      if (offs < `BDMA_ACCESS_SPLIT) begin
         window_addr = `BDMA_ACCESS_LOW | {4'h0, offs}; // RULE11 RULE20
      end else begin
         window_addr = `BDMA_ACCESS_HIGH | {4'h0, offs}; // RULE11 RULE20
      end
   endfunction

   // Resolves the data address of a single-word banked or window access
   function automatic bdma_addr_t resolve(input logic [`BDMA_WORD_W-1:0] word,
                                          input logic [`BDMA_BANK_W-1:0] bank);
      if (word[`BDMA_ACCESS_BIT]) begin
         resolve = {bank, word[`BDMA_OFFS_W-1:0]}; // RULE6 RULE12
      end else begin
         resolve = window_addr(word[`BDMA_OFFS_W-1:0]); // RULE13 RULE14
      end
   endfunction

   function automatic logic bank_present(input bdma_addr_t addr);
      bank_present = {1'b0, addr[`BDMA_ADDR_W-1 -: `BDMA_BANK_W]} < `BDMA_BANKS_IMPL; // RULE4
   endfunction

   function automatic logic in_sfr(input bdma_addr_t addr);
      in_sfr = addr >= `BDMA_SFR_BASE; // RULE18
   endfunction

   // Single-word operations that read an operand and pulse the flags
   function automatic logic is_data_op(input bdma_op_t op);
      is_data_op = (op == BDMA_OP_READ) || (op == BDMA_OP_WRITE);
   endfunction

   // Address an incoming word will use; a move source is a full address
   function automatic bdma_addr_t cmd_addr(input bdma_op_t                op,
                                           input logic [`BDMA_WORD_W-1:0] word,
                                           input logic [`BDMA_BANK_W-1:0] bank);
      if (op == BDMA_OP_MOVE_FIRST) begin
         cmd_addr = word[`BDMA_ADDR_W-1:0]; // RULE10
      end else begin
         cmd_addr = resolve(word, bank);
      end
   endfunction

   assign q1_tick = (q_phase_r == `BDMA_Q1);
   assign q2_tick = (q_phase_r == `BDMA_Q2);
   assign q4_tick = (q_phase_r == `BDMA_Q4);

   // Word with the top nibble all ones is the literal-carrying second word
   assign is_second = (ir_word_r[`BDMA_NIBBLE_HI:`BDMA_NIBBLE_LO] == `BDMA_SECOND_NIBBLE); // RULE1

   // Address of the current word; a move uses its full 12-bit fields
   always_comb begin
      eff_alt  = 1'b0;
      eff_addr = resolve(ir_word_r, bank_pointer_r);
      if (ir_op_r == BDMA_OP_MOVE_FIRST || is_second) begin
         eff_addr = ir_word_r[`BDMA_ADDR_W-1:0]; // RULE10 RULE3
      end else if (extended_set_enable && !ir_word_r[`BDMA_ACCESS_BIT]) begin
         eff_alt = 1'b1; // RULE15
      end
   end

   // Destination write selected for the Q4 edge
   always_comb begin
      wr_en   = 1'b0;
      wr_data = cmd_wdata;
      if (ir_op_r == BDMA_OP_WRITE && !eff_alt) begin
         wr_en = bank_present(eff_addr); // RULE9
      end else if (is_second && move_pending_r) begin
         wr_en   = bank_present(eff_addr); // RULE2 RULE9
         wr_data = move_data_r;
      end
   end

   // Operand source: pointer register, special area or general RAM
   always_comb begin
      if (eff_alt || !bank_present(eff_addr)) begin
         rd_mux = '0; // RULE5 RULE9
      end else if (eff_addr == `BDMA_BANK_PTR_ADDR) begin
         rd_mux = {4'h0, bank_pointer_r}; // RULE7
      end else if (in_sfr(eff_addr)) begin
         rd_mux = sfr_rdata; // RULE18
      end else begin
         rd_mux = ram_bus.rdata;
      end
   end

   assign ram_bus.addr  = eff_addr;
   assign ram_bus.wdata = wr_data;
   assign ram_bus.we    = q4_tick && wr_en && !in_sfr(eff_addr); // RULE19 RULE16

   // Operand read strobe; the alternate window is resolved outside
   assign rd_take    = q2_tick && !eff_alt
                       && (is_data_op(ir_op_r) || ir_op_r == BDMA_OP_MOVE_FIRST); // RULE19 RULE15

   // Address of the incoming word, for the early peripheral read strobe
   assign next_addr  = cmd_addr(cmd_op, cmd_word, bank_pointer_r);
   assign sfr_rd_req = q1_tick && in_sfr(next_addr)
                       && (is_data_op(cmd_op) || cmd_op == BDMA_OP_MOVE_FIRST); // RULE18

   // Peripheral and pc low writes at the Q4 edge; the pointer stays inside
   assign sfr_wr_req = q4_tick && wr_en && in_sfr(eff_addr) && eff_addr != `BDMA_BANK_PTR_ADDR; // RULE18
   assign pc_hit     = q4_tick && wr_en && eff_addr == `BDMA_PCL_ADDR; // RULE17

   bdma_ram u_ram (
      .clock  (clock),
      .port_m (ram_bus.mem)
   );

   // Divides the clock into the four instruction-cycle phases
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q_phase_r <= `BDMA_Q1;
      end else begin
         q_phase_r <= q_phase_r + 2'h1;
      end
   end

   // Instruction register, loaded once per instruction cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ir_op_r   <= BDMA_OP_NONE;
         ir_word_r <= '0;
      end else if (q1_tick) begin
         ir_op_r   <= cmd_op;
         ir_word_r <= cmd_word;
      end
   end

   // Bank pointer: literal load or a data write to its own location
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bank_pointer_r <= `BDMA_BANK_RESET;
      end else if (q4_tick) begin
         if (ir_op_r == BDMA_OP_LOAD_BANK) begin
            bank_pointer_r <= ir_word_r[`BDMA_BANK_W-1:0]; // RULE8 RULE7
         end else if (wr_en && eff_addr == `BDMA_BANK_PTR_ADDR) begin
            bank_pointer_r <= wr_data[`BDMA_BANK_W-1:0]; // RULE7
         end
      end
   end

   // Operand strobe, set at the Q2 edge together with the sampled value
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_take; // RULE19
      end
   end

   // Operand value sampled at the Q2 edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data_r <= '0;
      end else if (rd_take) begin
         rd_data_r <= rd_mux; // RULE19 RULE5
      end
   end

   // Address of the last operand read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         data_addr_r <= '0;
      end else if (rd_take) begin
         data_addr_r <= eff_addr; // RULE3
      end
   end

   // Move source captured in the first word's Q2
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         move_data_r <= '0;
      end else if (q2_tick && ir_op_r == BDMA_OP_MOVE_FIRST) begin
         move_data_r <= rd_mux; // RULE10
      end
   end

   // Second word consumes the literal only straight after the first word
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         move_pending_r <= 1'b0;
      end else if (q4_tick) begin
         move_pending_r <= (ir_op_r == BDMA_OP_MOVE_FIRST); // RULE2
      end
   end

   // Second word reached on its own is a no-op
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nop_exec_r <= 1'b0;
      end else begin
         nop_exec_r <= q4_tick && is_second && !move_pending_r; // RULE2
      end
   end

   // Status flags update even when the target bank is absent
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags_update_r <= 1'b0;
      end else begin
         flags_update_r <= q4_tick && is_data_op(ir_op_r); // RULE9
      end
   end

   // Window under the extended set is resolved outside
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alt_map_req_r <= 1'b0;
      end else begin
         alt_map_req_r <= q2_tick && eff_alt && is_data_op(ir_op_r); // RULE15
      end
   end

   // Program counter low byte write alters program flow
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_low_byte_we_r <= 1'b0;
      end else begin
         pc_low_byte_we_r <= pc_hit; // RULE17
      end
   end

   // Value written to the program counter low byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_low_byte_data_r <= '0;
      end else if (pc_hit) begin
         pc_low_byte_data_r <= wr_data; // RULE17
      end
   end

   // Peripheral write strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_we_r <= 1'b0;
      end else begin
         sfr_we_r <= sfr_wr_req; // RULE18 RULE19
      end
   end

   // Peripheral read strobe, one clock ahead of the Q2 sample
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_re_r <= 1'b0;
      end else begin
         sfr_re_r <= sfr_rd_req; // RULE18
      end
   end

   // Peripheral address: write target at Q4, next operand at Q1
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_addr_r <= '0;
      end else if (sfr_wr_req) begin
         sfr_addr_r <= eff_addr; // RULE18
      end else if (sfr_rd_req) begin
         sfr_addr_r <= next_addr; // RULE18
      end
   end

   // Peripheral write data
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_wdata_r <= '0;
      end else if (sfr_wr_req) begin
         sfr_wdata_r <= wr_data; // RULE18
      end
   end

endmodule

//--- sim/bdma_top_properties.sv
/*
 Port timing and address forming checks of the addressing block.
 Assumes binding to the top module; one clock, reset active high.
*/
module bdma_top_properties (
   input wire logic               clock,
   input wire logic               rst,
   input wire bdma_pkg::bdma_op_t cmd_op,
   input wire logic [15:0]        cmd_word,
   input wire logic               extended_set_enable,
   input wire logic [1:0]         q_phase_r,
   input wire logic [3:0]         bank_pointer_r,
   input wire logic [11:0]        data_addr_r,
   input wire logic [7:0]         rd_data_r,
   input wire logic               rd_valid_r,
   input wire logic               flags_update_r,
   input wire logic               nop_exec_r,
   input wire logic               alt_map_req_r,
   input wire logic               pc_low_byte_we_r,
   input wire logic               sfr_we_r,
   input wire logic [11:0]        sfr_addr_r
);
   timeunit 1ns;
   timeprecision 1ps;
   import bdma_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_RD_Q2: assert property (rd_valid_r |-> q_phase_r == 2'h2 ##1 !rd_valid_r)
      else $error("operand strobe off its phase");
   AST_FLAGS_Q4: assert property (flags_update_r |-> q_phase_r == 2'h0 ##1 !flags_update_r)
      else $error("flag pulse off its phase");
   AST_NOP_Q4: assert property (nop_exec_r |-> q_phase_r == 2'h0 && !flags_update_r && !sfr_we_r)
      else $error("lone second word did work");
   AST_PC_FF9: assert property (pc_low_byte_we_r |-> sfr_we_r && sfr_addr_r == 12'hFF9)
      else $error("pc low write at wrong address");
   AST_BANK_Q4: assert property (!$stable(bank_pointer_r) |-> q_phase_r == 2'h0)
      else $error("bank pointer changed off Q4");
   AST_WINDOW: assert property (rd_valid_r && cmd_op == BDMA_OP_READ && !cmd_word[8] && !extended_set_enable
      |-> data_addr_r == {cmd_word[7] ? 4'hF : 4'h0, cmd_word[7:0]}) else $error("window address wrong");
   AST_BANKED: assert property (rd_valid_r && cmd_op == BDMA_OP_READ && cmd_word[8]
      |-> data_addr_r == {bank_pointer_r, cmd_word[7:0]}) else $error("banked address wrong");
   AST_PTR_READ: assert property (rd_valid_r && data_addr_r == 12'hFE0 |-> rd_data_r == {4'h0, bank_pointer_r})
      else $error("pointer read upper bits set");
   AST_ALT_NOACC: assert property (alt_map_req_r |-> !rd_valid_r && q_phase_r == 2'h2)
      else $error("alternate window accessed");
   cover property (nop_exec_r);
   cover property (pc_low_byte_we_r);
   cover property (alt_map_req_r);
endmodule

bind bdma_top bdma_top_properties props (.clock, .rst, .cmd_op, .cmd_word, .extended_set_enable, .q_phase_r,
   .bank_pointer_r, .data_addr_r, .rd_data_r, .rd_valid_r, .flags_update_r, .nop_exec_r, .alt_map_req_r,
   .pc_low_byte_we_r, .sfr_we_r, .sfr_addr_r);

//--- sim/bdma_sfr_model.sv
/*
 Peripheral register model behind the special register port.
 Assumes address and read strobe steady in the clock before the Q2 edge.
*/
module bdma_sfr_model (
   input  wire logic        clock,
   input  wire logic        sfr_re_r,
   input  wire logic        sfr_we_r,
   input  wire logic [11:0] sfr_addr_r,
   input  wire logic [7:0]  sfr_wdata_r,
   output logic [7:0]       sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] regs [128];
   logic [7:0] junk = 8'hA5;
   initial for (int j = 0; j < 128; j++) regs[j] = 8'h80 ^ 8'h3C ^ j[7:0];
   always @(posedge clock) begin
      junk <= junk + 8'h35;
      if (sfr_we_r) regs[sfr_addr_r[6:0]] <= sfr_wdata_r;
   end
   // Unselected port shows a moving pattern
   assign sfr_rdata = sfr_re_r ? regs[sfr_addr_r[6:0]] : junk;
endmodule

//--- sim/tb_banked_data_memory_addressing.sv
/*
 Self-checking bench of the addressing block against an integer model.
 Assumes design, peripheral model and checker compiled first.
*/
`include "bdma_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t %0h %0h", $time, a, e); end end

module tb_banked_data_memory_addressing;
   timeunit 1ns;
   timeprecision 1ps;
   import bdma_pkg::*;
   logic        clock = 0, rst = 1, extended_set_enable = 0;
   bdma_op_t    cmd_op = BDMA_OP_NONE;
   logic [15:0] cmd_word = 16'h0;
   logic [7:0]  cmd_wdata = 8'h0, sfr_rdata, rd_data_r, pc_low_byte_data_r, sfr_wdata_r;
   logic [11:0] data_addr_r, sfr_addr_r;
   logic [3:0]  bank_pointer_r;
   logic [1:0]  q_phase_r;
   logic        rd_valid_r, flags_update_r, nop_exec_r, alt_map_req_r, pc_low_byte_we_r, sfr_we_r, sfr_re_r;
   logic        move_pending_r;
   int          error_cnt = 0, num_checks = 0, bk = 0, m[4096], e_pcd = 0, e_sa = 0, sv = 0, i;
   bit          kn[4096], mv = 0, e_fu = 0, e_nop = 0, e_pc = 0, e_sw = 0;
   logic [31:0] rs = 32'h145738AE, r;

   bdma_top dut (.clock, .rst, .cmd_op, .cmd_word, .cmd_wdata, .extended_set_enable, .sfr_rdata, .q_phase_r,
      .bank_pointer_r, .data_addr_r, .rd_data_r, .rd_valid_r, .flags_update_r, .nop_exec_r, .alt_map_req_r,
      .move_pending_r, .pc_low_byte_we_r, .pc_low_byte_data_r, .sfr_we_r, .sfr_re_r, .sfr_addr_r, .sfr_wdata_r);
   bdma_sfr_model sfr (.clock, .sfr_re_r, .sfr_we_r, .sfr_addr_r, .sfr_wdata_r, .sfr_rdata);

   always #10 clock = ~clock;

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   function automatic void wr(int a, int d);
      if (a == 12'hFE0) bk = d % 16;
      else begin
         m[a] = d;
         kn[a] = 1;
      end
      e_pc = a == 12'hFF9;
      e_pcd = d;
      e_sa = a;
      e_sw = a >= 12'hF80 && a != 12'hFE0;
   endfunction

   task automatic close_out;
      if (error_cnt == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Called at an edge that closes Q4; checks the pulses of the previous word
   task automatic op(input bdma_op_t o, input logic [15:0] w, input logic [7:0] d);
      int a;
      bit alt;
      cmd_op <= o;
      cmd_word <= w;
      cmd_wdata <= d;
      #1;
      `CHK(flags_update_r, e_fu)
      `CHK(nop_exec_r, e_nop)
      `CHK(pc_low_byte_we_r, e_pc)
      `CHK(sfr_we_r, e_sw)
      if (e_sw) `CHK(sfr_addr_r, e_sa[11:0])
      if (e_sw) `CHK(sfr_wdata_r, e_pcd[7:0])
      `CHK(move_pending_r, mv)
      if (e_pc) `CHK(pc_low_byte_data_r, e_pcd)
      `CHK(bank_pointer_r, bk)
      a = w[8] ? bk * 256 + w[7:0] : (w[7] ? 12'hF00 + w[7:0] : w[7:0]);
      alt = extended_set_enable && !w[8] && (o == BDMA_OP_READ || o == BDMA_OP_WRITE);
      e_fu = o == BDMA_OP_READ || o == BDMA_OP_WRITE;
      e_nop = o == BDMA_OP_SECOND && !mv;
      e_pc = 0;
      e_sw = 0;
      repeat (2) @(posedge clock);
      #1;
      `CHK(alt_map_req_r, alt)
      if (alt) `CHK(rd_valid_r, 1'b0)
      if (o == BDMA_OP_READ && !alt && kn[a]) begin
         `CHK(rd_valid_r, 1'b1)
         `CHK(data_addr_r, a[11:0])
         `CHK(rd_data_r, a == 12'hFE0 ? bk : m[a])
      end
      if (o == BDMA_OP_WRITE && !alt) wr(a, d);
      if (o == BDMA_OP_MOVE_FIRST) sv = m[w[11:0]];
      if (o == BDMA_OP_SECOND && mv) wr(w[11:0], sv);
      if (o == BDMA_OP_LOAD_BANK) bk = w[3:0];
      mv = o == BDMA_OP_MOVE_FIRST;
      repeat (2) @(posedge clock);
   endtask

   initial begin
      #200us;
      error_cnt++;
      close_out();
   end

   initial begin
      for (i = 12'hF80; i < 4096; i++) begin
         m[i] = (i ^ 32'h3C) & 32'hFF;
         kn[i] = 1;
      end
      repeat (16) @(posedge clock);
      rst <= 0;
      do @(negedge clock); while (q_phase_r !== 2'h3);
      @(posedge clock);
      for (i = 0; i < 16; i++) begin
         op(BDMA_OP_LOAD_BANK, 16'h00F0 | i, 0);
         op(BDMA_OP_WRITE, 16'h0155, 8'h40 + i);
      end
      for (i = 0; i < 16; i++) begin
         op(BDMA_OP_LOAD_BANK, i, 0);
         op(BDMA_OP_READ, 16'h0155, 0);
      end
      op(BDMA_OP_READ, 16'h0055, 0);
      op(BDMA_OP_WRITE, 16'h00E0, 8'hF2);
      op(BDMA_OP_READ, 16'h00E0, 0);
      op(BDMA_OP_MOVE_FIRST, 16'hC355, 0);
      op(BDMA_OP_SECOND, 16'hF020, 0);
      op(BDMA_OP_READ, 16'h0020, 0);
      op(BDMA_OP_SECOND, 16'hF055, 8'hEE);
      op(BDMA_OP_READ, 16'h0055, 0);
      op(BDMA_OP_LOAD_BANK, 16'h000F, 0);
      op(BDMA_OP_WRITE, 16'h01F9, 8'h5A);
      extended_set_enable <= 1;
      op(BDMA_OP_READ, 16'h0020, 0);
      op(BDMA_OP_WRITE, 16'h0020, 8'h99);
      extended_set_enable <= 0;
      op(BDMA_OP_READ, 16'h0020, 0);
      repeat (300) begin
         r = xs();
         op(r[1:0] == 0 ? BDMA_OP_LOAD_BANK : (r[0] ? BDMA_OP_READ : BDMA_OP_WRITE),
            {7'h0, r[8], r[9] ? {3'h7, r[14:10]} : {4'h0, r[13:10]}}, r[31:24]);
      end
      op(BDMA_OP_NONE, 0, 0);
      close_out();
   end
endmodule
